/* sts_defines.svh */
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH

// clock and timing
`define STS_CLK_NS 10
`define STS_GLITCH_NS 50
`define STS_GLITCH_CYC ((`STS_GLITCH_NS + `STS_CLK_NS - 1) / `STS_CLK_NS)
`define STS_TIMEOUT_NS 25000000
`define STS_TIMEOUT_CYC ((`STS_TIMEOUT_NS + `STS_CLK_NS - 1) / `STS_CLK_NS)

// address
`define STS_ADDR_BASE 4'h9
`define STS_SEL_FLOAT 2'h0
`define STS_SEL_GND 2'h1
`define STS_SEL_VDD 2'h2

// pointer codes
`define STS_PTR_TEMP 3'h0
`define STS_PTR_CFG 3'h1
`define STS_PTR_UPPER 3'h2
`define STS_PTR_LOWER 3'h3
`define STS_PTR_STATUS 3'h4
`define STS_PTR_ID 3'h7

// configuration fields
`define STS_CFG_ALERT_EN 5
`define STS_CFG_ALERT_POL 4
`define STS_CFG_ALERT_RST 3

// status fields
`define STS_ST_ALERT 3
`define STS_ST_ABOVE 2
`define STS_ST_BELOW 1

// reset values
`define STS_TEMP_RST 16'h7ffc
`define STS_CFG_RST 8'h40
`define STS_UPPER_RST 16'h7fe0
`define STS_LOWER_RST 16'h8000

// compare field: upper 11 temperature bits
`define STS_CMP_HI 15
`define STS_CMP_LO 5

`endif

/* sts_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module sts_host_model #(
  parameter int P_HALF = 250
) (
  // resolved data wire
  input wire logic i_sda,
  // master owns the clock; data is only pulled low or let go
  output logic o_scl,
  output logic o_sda_low
);
  localparam int Q = P_HALF / 2;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // data moves a quarter bit after the clock falls, never beside it
  task automatic start();
    #Q o_sda_low = 1'b0;
    #Q o_scl = 1'b1;
    #P_HALF o_sda_low = 1'b1;
    #P_HALF o_scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q o_sda_low = 1'b1;
    #Q o_scl = 1'b1;
    #P_HALF o_sda_low = 1'b0;
    #P_HALF;
  endtask : stop
  task automatic put_bit(input logic b);
    #Q o_sda_low = !b;
    #Q o_scl = 1'b1;
    #P_HALF o_scl = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    #Q o_sda_low = 1'b0;
    #Q o_scl = 1'b1;
    #Q b = i_sda;
    #Q o_scl = 1'b0;
  endtask : get_bit
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(b);
    ack = !b;
  endtask : wr_byte
  // a final byte is answered by letting data float
  task automatic rd_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      get_bit(v[i]);
    put_bit(last);
  endtask : rd_byte
endmodule : sts_host_model

`default_nettype wire

/* sts_line_filter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sts_defines.svh"

module sts_line_filter #(
  parameter int unsigned P_TIMEOUT_CYC = `STS_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // line
  sts_line_if.filt line
);

  localparam logic [3:0] GLITCH_CYC = 4'(`STS_GLITCH_CYC);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic clean;
    logic [3:0] cnt;
    logic [31:0] low_cnt;
  } sts_filt_s;

  sts_filt_s st_reg;
  sts_filt_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = line.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // only a level that stays put for the whole window gets through
    if ((st_reg.s2 == st_reg.s3) && (st_reg.s2 != st_reg.clean))
    begin
      if (st_reg.cnt >= GLITCH_CYC - 4'h1)
      begin
        st_next.clean = st_reg.s2;
        st_next.cnt = 4'h0;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
    else
    begin
      st_next.cnt = 4'h0;
    end
    // saturating low-time counter for the stuck-bus check
    if (!st_reg.clean)
    begin
      if (st_reg.low_cnt != 32'hffffffff)
      begin
        st_next.low_cnt = st_reg.low_cnt + 32'h1;
      end
    end
    else
    begin
      st_next.low_cnt = 32'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, clean: 1'b1,
                 cnt: 4'h0, low_cnt: 32'h0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign line.clean = st_reg.clean;
  assign line.stuck = !st_reg.clean && (st_reg.low_cnt >= P_TIMEOUT_CYC);

endmodule : sts_line_filter

`default_nettype wire

/* sts_line_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface sts_line_if;
  logic raw;
  logic clean;
  logic stuck;

  modport filt (input raw, output clean, output stuck);
  modport user (output raw, input clean, input stuck);
endinterface : sts_line_if

`default_nettype wire

/* sts_pkg.sv */
package sts_pkg;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_PTR       = 9'h008,
    ST_PTR_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } sts_state_e;

  typedef logic [15:0] sts_word_t;

endpackage : sts_pkg

/* sts_slave.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sts_defines.svh"

module sts_slave #(
  parameter int unsigned P_TIMEOUT_CYC = `STS_TIMEOUT_CYC,
  parameter logic [15:0] P_ID_VALUE = 16'h00a5 // arbitrary value
) (
  // system clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  // serial bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // address straps
  input wire logic I_VARIANT,
  input wire logic [1:0] I_ADDR_SEL,
  // converter side, own clock
  input wire logic I_CONV_CLK,
  input wire logic I_CONV_DONE,
  input wire logic [15:0] I_CONV_DATA,
  // alert response address cycle finished elsewhere
  input wire logic I_ARA_DONE,
  // alert and status
  output logic O_ALERT,
  output logic O_ALERT_STATUS,
  output logic O_ABOVE_FLAG,
  output logic O_BELOW_FLAG,
  output logic [2:0] O_POINTER,
  output logic [7:0] O_CONFIG,
  output logic [15:0] O_TEMP
);

  ////////////////////////////////////////////////////////////////////////////
  // line filters

  sts_line_if scl_line ();
  sts_line_if sda_line ();

  assign scl_line.raw = I_SCL;
  assign sda_line.raw = I_SDA;

  sts_line_filter #(
    .P_TIMEOUT_CYC(P_TIMEOUT_CYC)
  ) u_scl_filter (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .line(scl_line)
  );

  sts_line_filter #(
    .P_TIMEOUT_CYC(P_TIMEOUT_CYC)
  ) u_sda_filter (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .line(sda_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  // converter domain: hold the result and flip a toggle per conversion

  typedef struct packed {
    logic tog;
    logic [15:0] data;
  } sts_conv_s;

  sts_conv_s cv_reg;
  sts_conv_s cv_next;

  always_comb
  begin
    cv_next = cv_reg;
    if (I_CONV_DONE)
    begin
      // reserved low bits always read as zero
      cv_next.data = {I_CONV_DATA[15:2], 2'h0};
      cv_next.tog = !cv_reg.tog;
    end
  end

  always_ff @(posedge I_CONV_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      cv_reg <= '{tog: 1'b0, data: `STS_TEMP_RST};
    end
    else
    begin
      cv_reg <= cv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain state

  typedef struct packed {
    sts_pkg::sts_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic mack;
    logic [1:0] byte_idx;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    logic [2:0] ptr;
    logic [7:0] cfg;
    sts_pkg::sts_word_t upper;
    sts_pkg::sts_word_t lower;
    sts_pkg::sts_word_t temp;
    logic alert;
    logic above;
    logic below;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
  } sts_main_s;

  sts_main_s st_reg;
  sts_main_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  logic [6:0] own_addr;
  logic [1:0] sel_code;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic bus_stuck;
  logic conv_evt;
  logic alert_clear_wr;
  logic ptr_ok;
  logic alert_pin;
  logic alert_act;

  // an open or unknown select code falls back to the floating address
  assign sel_code = (I_ADDR_SEL == `STS_SEL_GND) ? 2'h1 :
                    (I_ADDR_SEL == `STS_SEL_VDD) ? 2'h2 : 2'h0;
  assign own_addr = {`STS_ADDR_BASE, I_VARIANT, sel_code};

  assign scl_rise = scl_line.clean && !st_reg.scl_d;
  assign scl_fall = !scl_line.clean && st_reg.scl_d;
  assign start_cond = st_reg.scl_d && scl_line.clean &&
                      st_reg.sda_d && !sda_line.clean;
  assign stop_cond = st_reg.scl_d && scl_line.clean &&
                     !st_reg.sda_d && sda_line.clean;
  assign bus_stuck = scl_line.stuck || sda_line.stuck;

  // only the synchroniser's second and third stages are compared
  assign conv_evt = st_reg.tog_s2 ^ st_reg.tog_s3;

  function automatic logic ptr_valid(input logic [7:0] b);
    logic hit;
    hit = (b[2:0] == `STS_PTR_TEMP) || (b[2:0] == `STS_PTR_CFG) ||
          (b[2:0] == `STS_PTR_UPPER) || (b[2:0] == `STS_PTR_LOWER) ||
          (b[2:0] == `STS_PTR_STATUS) || (b[2:0] == `STS_PTR_ID);
    return hit && (b[7:3] == 5'h00);
  endfunction : ptr_valid

  function automatic logic [7:0] read_byte(
    input logic [2:0] p,
    input logic [1:0] idx,
    input sts_main_s s,
    input logic mirror
  );
    logic [15:0] w;
    logic wide;
    w = 16'h0000;
    wide = 1'b1;
    unique case (p)
      `STS_PTR_TEMP: w = s.temp;
      `STS_PTR_UPPER: w = s.upper;
      `STS_PTR_LOWER: w = s.lower;
      `STS_PTR_ID: w = P_ID_VALUE;
      `STS_PTR_CFG:
      begin
        w = {8'h00, s.cfg};
        wide = 1'b0;
      end
      default:
      begin
        w = 16'h0000;
        w[`STS_ST_ALERT] = mirror;
        w[`STS_ST_ABOVE] = s.above;
        w[`STS_ST_BELOW] = s.below;
        wide = 1'b0;
      end
    endcase
    // two-byte registers give high then low; bytes three and four repeat low, and from the fifth byte on the read index wraps to 0 and gives high
    if (wide && (idx == 2'h0))
    begin
      return w[15:8];
    end
    return w[7:0];
  endfunction : read_byte

  ////////////////////////////////////////////////////////////////////////////
  // alert output: enable gates it, polarity sets the pin level

  assign alert_act = st_reg.alert && !st_reg.cfg[`STS_CFG_ALERT_EN];
  assign alert_pin = st_reg.cfg[`STS_CFG_ALERT_POL] ? alert_act
                                                    : !alert_act;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic signed [10:0] t_cmp;
    logic signed [10:0] hi_cmp;
    logic signed [10:0] lo_cmp;
    logic [7:0] b;
    st_next = st_reg;
    t_cmp = 11'sh000;
    hi_cmp = $signed(st_reg.upper[`STS_CMP_HI:`STS_CMP_LO]);
    lo_cmp = $signed(st_reg.lower[`STS_CMP_HI:`STS_CMP_LO]);
    b = 8'h00;
    alert_clear_wr = 1'b0;
    ptr_ok = 1'b0;
    st_next.scl_d = scl_line.clean;
    st_next.sda_d = sda_line.clean;
    st_next.tog_s1 = cv_reg.tog;
    st_next.tog_s2 = st_reg.tog_s1;
    st_next.tog_s3 = st_reg.tog_s2;

    unique case (st_reg.state)
      sts_pkg::ST_IDLE:
      begin
        st_next.sda_oe = 1'b0;
      end
      sts_pkg::ST_ADDR:
      begin
        if (scl_rise)
        begin
          st_next.shift = {st_reg.shift[6:0], sda_line.clean};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        else if (scl_fall && (st_reg.bit_cnt == 4'h8))
        begin
          st_next.bit_cnt = 4'h0;
          if (st_reg.shift[7:1] == own_addr)
          begin
            st_next.rw = st_reg.shift[0];
            st_next.sda_oe = 1'b1;
            st_next.state = sts_pkg::ST_ADDR_ACK;
          end
          else
          begin
            st_next.state = sts_pkg::ST_IDLE;
          end
        end
      end
      sts_pkg::ST_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          st_next.byte_idx = 2'h0;
          if (st_reg.rw)
          begin
            // read with no pointer byte uses the stored pointer
            b = read_byte(st_reg.ptr, 2'h0, st_reg, alert_pin);
            st_next.shift = b;
            st_next.sda_oe = !b[7];
            st_next.state = sts_pkg::ST_RDATA;
          end
          else
          begin
            st_next.sda_oe = 1'b0;
            st_next.state = sts_pkg::ST_PTR;
          end
        end
      end
      sts_pkg::ST_PTR:
      begin
        if (scl_rise)
        begin
          st_next.shift = {st_reg.shift[6:0], sda_line.clean};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        else if (scl_fall && (st_reg.bit_cnt == 4'h8))
        begin
          st_next.bit_cnt = 4'h0;
          ptr_ok = ptr_valid(st_reg.shift);
          if (ptr_ok)
          begin
            st_next.ptr = st_reg.shift[2:0];
            st_next.sda_oe = 1'b1;
            st_next.state = sts_pkg::ST_PTR_ACK;
          end
          else
          begin
            st_next.state = sts_pkg::ST_IDLE;
          end
        end
      end
      sts_pkg::ST_PTR_ACK, sts_pkg::ST_WDATA_ACK:
      begin
        if (scl_fall)
        begin
          st_next.sda_oe = 1'b0;
          st_next.state = sts_pkg::ST_WDATA;
        end
      end
      sts_pkg::ST_WDATA:
      begin
        if (scl_rise)
        begin
          st_next.shift = {st_reg.shift[6:0], sda_line.clean};
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        else if (scl_fall && (st_reg.bit_cnt == 4'h8))
        begin
          st_next.bit_cnt = 4'h0;
          st_next.sda_oe = 1'b1;
          st_next.state = sts_pkg::ST_WDATA_ACK;
          if (st_reg.byte_idx != 2'h3)
          begin
            st_next.byte_idx = st_reg.byte_idx + 2'h1;
          end
          // read-only targets take the byte but keep their value
          unique case (st_reg.ptr)
            `STS_PTR_CFG:
            begin
              if (st_reg.byte_idx == 2'h0)
              begin
                st_next.cfg = st_reg.shift;
                st_next.cfg[`STS_CFG_ALERT_RST] = 1'b0;
                alert_clear_wr = st_reg.shift[`STS_CFG_ALERT_RST];
              end
            end
            `STS_PTR_UPPER:
            begin
              if (st_reg.byte_idx == 2'h0)
              begin
                st_next.upper[15:8] = st_reg.shift;
              end
              else if (st_reg.byte_idx == 2'h1)
              begin
                st_next.upper[7:0] = st_reg.shift;
              end
            end
            `STS_PTR_LOWER:
            begin
              if (st_reg.byte_idx == 2'h0)
              begin
                st_next.lower[15:8] = st_reg.shift;
              end
              else if (st_reg.byte_idx == 2'h1)
              begin
                st_next.lower[7:0] = st_reg.shift;
              end
            end
            default:
            begin
              st_next.cfg = st_reg.cfg;
            end
          endcase
        end
      end
      sts_pkg::ST_RDATA:
      begin
        if (scl_fall)
        begin
          if (st_reg.bit_cnt == 4'h7)
          begin
            st_next.bit_cnt = 4'h0;
            st_next.sda_oe = 1'b0;
            st_next.mack = 1'b0;
            st_next.state = sts_pkg::ST_RDATA_ACK;
          end
          else
          begin
            st_next.shift = {st_reg.shift[6:0], 1'b0};
            st_next.sda_oe = !st_reg.shift[6];
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
        end
      end
      sts_pkg::ST_RDATA_ACK:
      begin
        if (scl_rise)
        begin
          // a nack ends the read; either answer is fine
          if (sda_line.clean)
          begin
            st_next.state = sts_pkg::ST_IDLE;
          end
          else
          begin
            st_next.mack = 1'b1;
          end
        end
        else if (scl_fall && st_reg.mack)
        begin
          b = read_byte(st_reg.ptr, st_reg.byte_idx + 2'h1, st_reg,
                        alert_pin);
          if (st_reg.byte_idx != 2'h3)
          begin
            st_next.byte_idx = st_reg.byte_idx + 2'h1;
          end
          st_next.shift = b;
          st_next.sda_oe = !b[7];
          st_next.state = sts_pkg::ST_RDATA;
        end
      end
    endcase

    // start and stop override the byte machine, repeated start included
    if (start_cond)
    begin
      st_next.state = sts_pkg::ST_ADDR;
      st_next.bit_cnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      st_next.state = sts_pkg::ST_IDLE;
      st_next.sda_oe = 1'b0;
    end
    if (bus_stuck)
    begin
      st_next.state = sts_pkg::ST_IDLE;
      st_next.sda_oe = 1'b0;
      st_next.bit_cnt = 4'h0;
    end

    // alert: clears first so a conversion in the same cycle wins
    if (alert_clear_wr || I_ARA_DONE)
    begin
      st_next.alert = 1'b0;
    end
    if (conv_evt)
    begin
      st_next.temp = cv_reg.data;
      t_cmp = $signed(cv_reg.data[`STS_CMP_HI:`STS_CMP_LO]);
      st_next.above = (t_cmp > hi_cmp);
      st_next.below = (t_cmp < lo_cmp);
      if (t_cmp > hi_cmp)
      begin
        st_next.alert = 1'b1;
      end
      else if (t_cmp < lo_cmp)
      begin
        st_next.alert = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      st_reg <= '{state: sts_pkg::ST_IDLE, bit_cnt: 4'h0, shift: 8'h00,
                 rw: 1'b0, mack: 1'b0, byte_idx: 2'h0, sda_oe: 1'b0,
                 scl_d: 1'b1, sda_d: 1'b1, ptr: `STS_PTR_TEMP,
                 cfg: `STS_CFG_RST, upper: `STS_UPPER_RST,
                 lower: `STS_LOWER_RST, temp: `STS_TEMP_RST,
                 alert: 1'b0, above: 1'b0, below: 1'b0,
                 tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // open drain: the driven level is always low, never a high
  assign O_SDA = 1'b0;
  assign O_SDA_OE = st_reg.sda_oe;
  assign O_ALERT = alert_pin;
  assign O_ALERT_STATUS = alert_pin;
  assign O_ABOVE_FLAG = st_reg.above;
  assign O_BELOW_FLAG = st_reg.below;
  assign O_POINTER = st_reg.ptr;
  assign O_CONFIG = st_reg.cfg;
  assign O_TEMP = st_reg.temp;

endmodule : sts_slave

`default_nettype wire

/* sts_slave_assertions.sv */
`timescale 1ns/1ns
`default_nettype none

module sts_slave_checker #(
  parameter int unsigned P_TIMEOUT_CYC = 2000
) (
  // clock, reset and inputs
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_SCL,
  input wire logic I_CONV_DONE,
  input wire logic I_ARA_DONE,
  // watched outputs
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire logic O_ALERT,
  input wire logic O_ALERT_STATUS,
  input wire logic O_ABOVE_FLAG,
  input wire logic O_BELOW_FLAG,
  input wire logic [2:0] O_POINTER,
  input wire logic [7:0] O_CONFIG,
  input wire logic [15:0] O_TEMP
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);
  ////////////////////////////////////////////////////////////
  // age saturates, so a stale conversion never excuses a change
  logic [5:0] age_reg;
  logic [31:0] low_reg;
  logic act;
  assign act = (O_ALERT == O_CONFIG[4]) && !O_CONFIG[5];
  always_ff @(posedge I_SYS_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      age_reg <= 6'h3f;
      low_reg <= 32'h0;
    end
    else
    begin
      age_reg <= I_CONV_DONE ? 6'h00 : age_reg + {5'h0, age_reg != 6'h3f};
      low_reg <= I_SCL ? 32'h0 : low_reg + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_ara; I_ARA_DONE && age_reg > 6'h1e; endsequence
  sequence s_off; ##[1:4] !act; endsequence
  property p_mirror; O_ALERT_STATUS == O_ALERT; endproperty
  a_mirror: assert property (p_mirror) else $error("mirror");
  // the data line is only taken while the clock is low; it may stay taken across a high
  property p_drain;
    O_SDA_OE |-> !O_SDA && (!$rose(O_SDA_OE) || !I_SCL);
  endproperty
  a_drain: assert property (p_drain) else $error("drive");
  property p_off; O_CONFIG[5] |-> O_ALERT == !O_CONFIG[4]; endproperty
  a_off: assert property (p_off) else $error("off level");
  property p_ptr; O_POINTER != 3'h5 && O_POINTER != 3'h6; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer");
  property p_temp;
    !$stable(O_TEMP) |-> age_reg < 6'h18 && O_TEMP[1:0] == 2'h0;
  endproperty
  a_temp: assert property (p_temp) else $error("temp");
  property p_flag;
    !$stable({O_ABOVE_FLAG, O_BELOW_FLAG}) |-> age_reg < 6'h18;
  endproperty
  a_flag: assert property (p_flag) else $error("flags");
  property p_rise;
    $rose(act) |-> age_reg < 6'h18 || $past(O_CONFIG[5]);
  endproperty
  a_rise: assert property (p_rise) else $error("alert rise");
  property p_ara; s_ara |-> s_off; endproperty
  a_ara: assert property (p_ara) else $error("ara");
  property p_stuck; low_reg > P_TIMEOUT_CYC + 40 |-> !O_SDA_OE; endproperty
  a_stuck: assert property (p_stuck) else $error("timeout");
endmodule : sts_slave_checker

bind sts_slave sts_slave_checker #(.P_TIMEOUT_CYC(P_TIMEOUT_CYC)) i_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_SCL(I_SCL),
  .I_CONV_DONE(I_CONV_DONE), .I_ARA_DONE(I_ARA_DONE), .O_SDA(O_SDA),
  .O_SDA_OE(O_SDA_OE), .O_ALERT(O_ALERT), .O_ALERT_STATUS(O_ALERT_STATUS),
  .O_ABOVE_FLAG(O_ABOVE_FLAG), .O_BELOW_FLAG(O_BELOW_FLAG),
  .O_POINTER(O_POINTER), .O_CONFIG(O_CONFIG), .O_TEMP(O_TEMP));

`default_nettype wire

/* sts_slave_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module sts_slave_tb;
  localparam int unsigned P_TO = 2000;
  localparam logic [7:0] BAD [3] = '{8'h05, 8'h06, 8'h0a};
  logic clk = 1'b0, cclk = 1'b0, rst = 1'b1, vsel = 1'b0, cdone = 1'b0;
  logic ara = 1'b0, a, scl, sda_low, sda_o, oe, alert, alert_st;
  logic above, below;
  logic [1:0] sel = 2'h0;
  logic [2:0] ptr;
  logic [7:0] cfg;
  logic [6:0] adr = 7'h48;
  logic [15:0] cdata = 16'h0000, temp, d;
  int n_errors = 0, checks = 0, cyc = 0;
  wire logic sda;
  assign sda = !(sda_low || oe);
  always #5 clk = !clk;
  initial
  begin
    #3;
    forever #24 cclk = !cclk;
  end
  sts_slave #(.P_TIMEOUT_CYC(P_TO)) i_dut (.I_SYS_CLK(clk), .I_RESET(rst),
    .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o), .O_SDA_OE(oe),
    .I_VARIANT(vsel), .I_ADDR_SEL(sel), .I_CONV_CLK(cclk),
    .I_CONV_DONE(cdone), .I_CONV_DATA(cdata), .I_ARA_DONE(ara),
    .O_ALERT(alert), .O_ALERT_STATUS(alert_st), .O_ABOVE_FLAG(above),
    .O_BELOW_FLAG(below), .O_POINTER(ptr), .O_CONFIG(cfg), .O_TEMP(temp));
  sts_host_model i_host (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic conv(input logic [15:0] v);
    @(posedge cclk);
    #1 cdata = v;
    cdone = 1'b1;
    @(posedge cclk);
    #1 cdone = 1'b0;
    tick(40);
  endtask : conv
  // optional pointer phase with written bytes, then optional read phase
  task automatic xfer(input logic wp, input logic [7:0] p, input int nw,
                      input logic [15:0] wv, input int nr);
    logic k;
    a = 1'b1;
    if (wp)
    begin
      i_host.start();
      i_host.wr_byte({adr, 1'b0}, k);
      a &= k;
      i_host.wr_byte(p, k);
      a &= k;
      for (int i = nw - 1; i >= 0; i--)
      begin
        i_host.wr_byte(wv[8*i +: 8], k);
        a &= k;
      end
    end
    if (nr > 0)
    begin
      i_host.start();
      i_host.wr_byte({adr, 1'b1}, k);
      a &= k;
      for (int i = nr - 1; i >= 0; i--)
        i_host.rd_byte(i == 0, d[8*i +: 8]);
    end
    i_host.stop();
  endtask : xfer
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    tick(12);
    rst = 1'b0;
    tick(20);
    chk(16'(ptr), 16'h0000);
    chk({cfg, 7'h0, alert}, 16'h4001);
    chk(temp, 16'h7ffc);
    $display("test reset done");
    for (int v = 0; v < 2; v++)
      for (int s = 0; s < 3; s++)
      begin
        vsel = 1'(v);
        sel = 2'(s);
        adr = {4'h9, vsel, sel};
        xfer(1'b1, 8'h00, 0, 16'h0, 0);
        chk(16'(a), 16'h0001);
        adr = {4'h9, !vsel, sel};
        xfer(1'b1, 8'h00, 0, 16'h0, 0);
        chk(16'(a), 16'h0000);
      end
    {vsel, sel, adr} = {3'h0, 7'h48};
    $display("test address done");
    xfer(1'b1, 8'h02, 0, 16'h0, 0);
    chk(16'(ptr), 16'h0002);
    foreach (BAD[i])
    begin
      xfer(1'b1, BAD[i], 0, 16'h0, 0);
      chk({a, 12'h0, ptr}, 16'h0002);
    end
    $display("test pointer done");
    xfer(1'b1, 8'h02, 2, 16'h1900, 0);
    xfer(1'b1, 8'h03, 2, 16'h0c80, 0);
    xfer(1'b1, 8'h01, 1, 16'h0050, 0);
    conv(16'h191c);
    chk(16'({alert, alert_st, above, below}), 16'h0000);
    conv(16'h1920);
    chk(16'({alert, alert_st, above, below}), 16'h000e);
    xfer(1'b1, 8'h00, 0, 16'h0, 2);
    chk(d, 16'h1920);
    xfer(1'b0, 8'h00, 0, 16'h0, 2);
    chk(d, 16'h1920);
    xfer(1'b1, 8'h04, 0, 16'h0, 1);
    chk(d & 16'h000e, 16'h000c);
    xfer(1'b1, 8'h01, 1, 16'h0058, 0);
    chk(16'({alert, cfg[3]}), 16'h0000);
    conv(16'h1920);
    chk(16'(alert), 16'h0001);
    @(posedge clk);
    #1 ara = 1'b1;
    @(posedge clk);
    #1 ara = 1'b0;
    tick(4);
    chk(16'(alert), 16'h0000);
    conv(16'h1920);
    conv(16'hff80);
    chk({alert, above, below, 1'b0, temp[15:4]}, 16'h2ff8);
    $display("test alert done");
    conv(16'h1920);
    xfer(1'b1, 8'h01, 1, 16'h0070, 0);
    chk(16'({alert, alert_st}), 16'h0000);
    xfer(1'b1, 8'h01, 1, 16'h0040, 0);
    chk(16'({alert, alert_st}), 16'h0000);
    xfer(1'b1, 8'h01, 1, 16'h0048, 0);
    chk(16'({alert, alert_st}), 16'h0003);
    $display("test polarity done");
    xfer(1'b1, 8'h02, 0, 16'h0, 0);
    i_host.start();
    i_host.wr_byte({adr, 1'b1}, a);
    tick(20);
    chk(16'(oe), 16'h0001);
    tick(P_TO + 60);
    chk(16'(oe), 16'h0000);
    i_host.stop();
    xfer(1'b1, 8'h00, 0, 16'h0, 2);
    chk({15'h0, a}, 16'h0001);
    $display("test timeout done");
    give_verdict();
  end
endmodule : sts_slave_tb

`default_nettype wire
